// ===== msl_defines.svh
`ifndef MSL_DEFINES_SVH
`define MSL_DEFINES_SVH
`define MSL_OFF_CTL   8'h00
`define MSL_OFF_STS   8'h04
`define MSL_OFF_EEI   8'h08
`define MSL_OFF_XA    8'h0C
`define MSL_OFF_XB    8'h10
`define MSL_OFF_XC    8'h14
`define MSL_CTL_SKIP  0
`define MSL_STS_FIN   0
`define MSL_STS_SUM   1
`define MSL_STS_NACK  2
`define MSL_STS_ARB   3
`define MSL_STS_MISC  4
`define MSL_STS_UNMAP 5
`define MSL_EEI_DATA  16
`define MSL_EEI_KIND  24
`define MSL_EEI_DONE  25
`define MSL_EEI_BUSY  26
`define MSL_EE_DEV_HI 3'h5
`define MSL_ARB_LAST  4'hF
`define MSL_SUM_OK    8'hFF
`define MSL_TY_SEQ    2'h1
`define MSL_TY_BAD    2'h2
`define MSL_TY_DONE   2'h3
`define MSL_HP_DEF    4'h5
`define MSL_HP_NEG    4'h3
`define MSL_HP_DIR    8'h0F
`define MSL_X_LINK    4'h8
`define MSL_X_ACT     4'h9
`define MSL_X_PGOOD   4'hA
`define MSL_PTR_END   16'hFFFF
`endif

// ===== msl_pkg.sv
package msl_pkg;
	typedef enum logic [1:0] {BO_START, BO_WR, BO_RD, BO_STOP} msl_bop_t;
	typedef enum logic [1:0] {TE_NONE, TE_NACK, TE_ARB, TE_MISC} msl_terr_t;
	typedef enum logic [1:0] {T_IDLE, T_ISSUE, T_WAIT} msl_tst_t;
	typedef enum logic [2:0] {M_BOOT, M_LREQ, M_LWAIT, M_IDLE, M_EWAIT, M_XREQ, M_XWAIT} msl_mst_t;
	typedef enum logic [2:0] {P_B0, P_B1, P_C0, P_C1, P_DATA} msl_ph_t;
	typedef struct packed {
		msl_bop_t   op;
		logic [7:0] data;
		logic       last;
	} msl_breq_t;
	typedef struct packed {
		logic [7:0] data;
		logic       nack;
		logic       arb_lost;
		logic       bad_cond;
	} msl_brsp_t;
	typedef struct packed {
		logic [6:0]  dev;
		logic        two_ptr;
		logic [15:0] ptr;
		logic        rd;
		logic [7:0]  wdata;
	} msl_txn_t;
	typedef struct packed {
		logic        wr;
		logic        rd;
		logic [7:0]  addr;
		logic [3:0]  be;
		logic [31:0] wdata;
	} msl_cfg_t;
	typedef struct packed {
		logic [13:0] addr;
		logic [31:0] data;
	} msl_ldw_t;
	typedef struct packed {
		msl_tst_t   st;
		logic [2:0] step;
		logic [3:0] arb;
		msl_txn_t   t;
		logic [7:0] rdata;
		msl_terr_t  err;
		logic       done;
	} msl_ts_t;
	typedef struct packed {
		msl_mst_t          st;
		msl_ph_t           ph;
		logic              go;
		msl_txn_t          txn;
		logic [15:0]       ptr;
		logic [7:0]        sum;
		logic [7:0]        b0;
		logic [1:0]        bi;
		logic [15:0]       cnt;
		logic [13:0]       addr;
		logic [31:0]       dw;
		logic              ldw_v;
		msl_ldw_t          ldw;
		logic              skip;
		logic              hold;
		logic [5:0]        sts;
		logic [15:0]       ee_addr;
		logic [7:0]        ee_data;
		logic              ee_rd;
		logic              ee_done;
		logic              ee_busy;
		logic [10:0][6:0]  xaddr;
		logic [10:0]       pend;
		logic [3:0]        scan;
		logic [3:0]        xsel;
		logic [2:0]        xstep;
		logic [10:0][15:0] xin;
		logic [31:0]       rdata;
	} msl_ms_t;
endpackage

// ===== msl_txn.sv
`timescale 1ns/1ps
`include "msl_defines.svh"
module msl_txn
	import msl_pkg::*;
(
	input  wire logic      clk_sys,
	input  wire logic      sys_rst,
	input  wire logic      go,
	input  wire msl_txn_t  txn,
	output logic           busy,
	output logic           done,
	output logic [7:0]     rdata,
	output msl_terr_t      err,
	output logic           be_go,
	output msl_breq_t      be_req,
	input  wire logic      be_done,
	input  wire msl_brsp_t be_rsp
);
	msl_ts_t    s_r;
	msl_ts_t    s_nxt;
	logic [2:0] last;

	// read: start, pointer, restart, read, stop; write: start, pointer, data, stop
	assign last = s_r.t.rd ? 3'd5 : 3'd4;
	assign busy = (s_r.st != T_IDLE);
	assign done = s_r.done;
	assign rdata = s_r.rdata;
	assign err = s_r.err;
	assign be_go = (s_r.st == T_ISSUE);

	always_comb begin
		be_req.op = BO_WR;
		be_req.data = 8'h00;
		be_req.last = 1'b0;
		case (s_r.step)
		3'd0: begin
			be_req.op = BO_START;
			be_req.data = {s_r.t.dev, 1'b0};
		end
		3'd1: be_req.data = s_r.t.ptr[15:8];
		3'd2: be_req.data = s_r.t.ptr[7:0];
		3'd3: begin
			if (s_r.t.rd) begin
				be_req.op = BO_START;
				be_req.data = {s_r.t.dev, 1'b1};
			end else begin
				be_req.data = s_r.t.wdata;
			end
		end
		3'd4: begin
			be_req.op = s_r.t.rd ? BO_RD : BO_STOP;
			be_req.last = 1'b1;
		end
		default: be_req.op = BO_STOP;
		endcase
	end

	always_comb begin
		s_nxt = s_r;
		s_nxt.done = 1'b0;
		case (s_r.st)
		T_IDLE: if (go) begin
			s_nxt.t = txn;
			s_nxt.step = 3'd0;
			s_nxt.err = TE_NONE;
			s_nxt.st = T_ISSUE;
		end
		T_ISSUE: s_nxt.st = T_WAIT;
		T_WAIT: if (be_done) begin
			s_nxt.st = T_ISSUE;
			if (be_rsp.bad_cond) begin
				s_nxt.err = TE_MISC;
				s_nxt.done = 1'b1;
				s_nxt.st = T_IDLE;
			end else if (be_rsp.arb_lost) begin
				s_nxt.arb = s_r.arb + 4'h1;
				s_nxt.step = 3'd0;
				if (s_r.arb == `MSL_ARB_LAST) begin
					s_nxt.err = TE_ARB;
					s_nxt.done = 1'b1;
					s_nxt.st = T_IDLE;
				end
			end else begin
				s_nxt.arb = 4'h0;
				if (be_req.op == BO_RD) begin
					s_nxt.rdata = be_rsp.data;
				end
				if (s_r.step == last) begin
					s_nxt.done = 1'b1;
					s_nxt.st = T_IDLE;
				end else if (be_rsp.nack && be_req.op != BO_RD) begin
					s_nxt.err = TE_NACK;
					s_nxt.step = last;
				end else if (s_r.step == 3'd0 && !s_r.t.two_ptr) begin
					s_nxt.step = 3'd2;
				end else begin
					s_nxt.step = s_r.step + 3'd1;
				end
			end
		end
		default: s_nxt.st = T_IDLE;
		endcase
	end

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	default clocking @(posedge clk_sys); endclocking
	default disable iff (sys_rst);

	arb_limit_a: assert property (s_r.st == T_WAIT && be_done && !be_rsp.bad_cond && be_rsp.arb_lost
		&& s_r.arb == `MSL_ARB_LAST |=> done && err == TE_ARB && !busy)
		else $error("sixteenth arbitration loss not reported");
	arb_retry_a: assert property (s_r.st == T_WAIT && be_done && !be_rsp.bad_cond && be_rsp.arb_lost
		&& s_r.arb != `MSL_ARB_LAST |=> be_go && be_req.op == BO_START && !done)
		else $error("arbitration loss did not restart the transfer");
	nack_stop_a: assert property (s_r.st == T_WAIT && be_done && !be_rsp.bad_cond && !be_rsp.arb_lost
		&& be_rsp.nack && be_req.op != BO_RD && s_r.step != last
		|=> err == TE_NACK ##1 be_req.op == BO_STOP)
		else $error("nack not turned into error and stop");
endmodule

// ===== msl_loader.sv
`timescale 1ns/1ps
`include "msl_defines.svh"
// Function
// - loader sums every byte read into 8 bits; valid image gives all ones
// - skip bit set: checksum mismatch is not checked nor an error
// - any load error stops loading, sets hold, records cause in status
// - finished flag set on normal end and on error abort
// - checksum mismatch sets sum error, hold and finished, aborts
// - undefined block type sets sum error, hold and finished, aborts
// - unexpected nack while loading sets no-ack error, hold, finished, aborts
// - sixteenth consecutive arbitration loss sets its error, hold, finished, aborts
// - misplaced start or stop sets misc error, hold, finished, aborts
// - eeprom read: data write starts it; done set, busy cleared, byte shown
// - eeprom write: data write starts it; done set, busy cleared at end
// - bus errors of eeprom accesses are reported in the status register
// - expanders 0-5 hot-plug, 8 link, 9 activity, 10 power good; two bytes
// - led outputs active low; hot-plug outputs driven without inversion
// - no expander transaction before eeprom loading has finished
// - writing an expander address field triggers its configuration writes, except for expanders 6 and 7
// - outputs of disabled ports driven to negated state; hot-plug pins of absent ports all set as inputs
// - hot-plug defaults bits 4-7: attention 1, power led 0, enable 1, lock 0
// - hot-plug order: regs 2,3 outputs, 4,5 zero, 6,7 direction, read 0,1
// - sixteen pins each; address fields grouped four, four, three in registers
// - block types: 0 single, 1 sequential, 3 done; read from zero to rollover
// - write to undefined register is ignored and sets the unmapped flag
module msl_loader
	import msl_pkg::*;
(
	input  wire logic             clk_sys,
	input  wire logic             sys_rst,
	input  wire logic             load_en,
	input  wire logic [3:0]       ee_addr_sel,
	input  wire msl_cfg_t         cfg,
	output logic [31:0]           cfg_rdata,
	output logic                  ldw_valid,
	output msl_ldw_t              ldw,
	input  wire logic             ldw_unmapped,
	output logic                  hold_after_reset,
	output logic                  load_finished,
	input  wire logic [11:0]      port_en,
	input  wire logic [11:0]      link_up,
	input  wire logic [11:0]      link_act,
	input  wire logic [11:0]      hp_ovr,
	input  wire logic [11:0][3:0] hp_ctl,
	output logic [10:0][15:0]     exp_in,
	output logic                  be_go,
	output msl_breq_t             be_req,
	input  wire logic             be_done,
	input  wire msl_brsp_t        be_rsp
);
	msl_ms_t           m_r;
	msl_ms_t           m_nxt;
	logic [6:0]        ee_dev;
	logic              t_done;
	logic [7:0]        t_rdata;
	msl_terr_t         t_err;
	logic [10:0][15:0] x_out;
	logic [10:0][15:0] x_dir;

	assign ee_dev = {`MSL_EE_DEV_HI, ee_addr_sel};
	assign cfg_rdata = m_r.rdata;
	assign ldw_valid = m_r.ldw_v;
	assign ldw = m_r.ldw;
	assign hold_after_reset = m_r.hold;
	assign load_finished = m_r.sts[`MSL_STS_FIN];
	assign exp_in = m_r.xin;

	msl_txn u_txn (
		.clk_sys (clk_sys),
		.sys_rst (sys_rst),
		.go      (m_r.go),
		.txn     (m_r.txn),
		.busy    (),
		.done    (t_done),
		.rdata   (t_rdata),
		.err     (t_err),
		.be_go   (be_go),
		.be_req  (be_req),
		.be_done (be_done),
		.be_rsp  (be_rsp)
	);

	// output value and direction image per expander; direction 1 is input
	for (genvar e = 0; e <= 10; e++) begin : g_x
		if (e <= 5) begin : g_hp
			localparam int PL = 4 * (e / 2) + 1 + (e % 2);
			localparam int PH = PL + 2;
			assign x_out[e][7:0] = {port_en[PL] ? (hp_ovr[PL] ? hp_ctl[PL] : `MSL_HP_DEF)
				: `MSL_HP_NEG, 4'hF};
			assign x_dir[e][7:0] = `MSL_HP_DIR;
			if (PH > 11) begin : g_rsv
				assign x_out[e][15:8] = 8'hFF;
				assign x_dir[e][15:8] = 8'hFF;
			end else begin : g_up
				assign x_out[e][15:8] = {port_en[PH] ? (hp_ovr[PH] ? hp_ctl[PH] : `MSL_HP_DEF)
					: `MSL_HP_NEG, 4'hF};
				assign x_dir[e][15:8] = `MSL_HP_DIR;
			end
		end else if (e == 8 || e == 9) begin : g_led
			// lit when low, dark for disabled ports
			assign x_out[e] = {4'hF, ~(port_en & (e == 8 ? link_up : link_act))};
			assign x_dir[e] = 16'h0000;
		end else if (e == 10) begin : g_pg
			assign x_out[e] = 16'hFFFF;
			assign x_dir[e] = 16'hFFFF;
		end else begin : g_none
			assign x_out[e] = 16'h0000;
			assign x_dir[e] = 16'hFFFF;
		end
	end

	function automatic logic [5:0] err_bits(input msl_terr_t e);
		err_bits = 6'h00;
		case (e)
		TE_NACK: err_bits[`MSL_STS_NACK] = 1'b1;
		TE_ARB:  err_bits[`MSL_STS_ARB] = 1'b1;
		TE_MISC: err_bits[`MSL_STS_MISC] = 1'b1;
		default: err_bits = 6'h00;
		endcase
	endfunction

	always_comb begin
		logic       abort;
		logic       fin;
		logic       xdone;
		logic [7:0] by;
		logic [7:0] sm;
		logic [7:0] wd;
		logic [15:0] xv;
		abort = 1'b0;
		fin = 1'b0;
		xdone = 1'b0;
		by = t_rdata;
		sm = m_r.sum + t_rdata;
		xv = m_r.xstep[2] ? x_dir[m_r.xsel] : x_out[m_r.xsel];
		wd = m_r.xstep[0] ? xv[15:8] : xv[7:0];
		m_nxt = m_r;
		m_nxt.go = 1'b0;
		m_nxt.ldw_v = 1'b0;

		// register writes
		if (cfg.wr && cfg.addr == `MSL_OFF_CTL && cfg.be[0]) begin
			m_nxt.skip = cfg.wdata[`MSL_CTL_SKIP];
		end
		if (cfg.wr && cfg.addr == `MSL_OFF_STS && cfg.be[0]) begin
			m_nxt.sts[5:1] = m_r.sts[5:1] & ~cfg.wdata[5:1];
		end
		if (cfg.wr && cfg.addr == `MSL_OFF_EEI && !m_r.ee_busy) begin
			if (cfg.be[0]) m_nxt.ee_addr[7:0] = cfg.wdata[7:0];
			if (cfg.be[1]) m_nxt.ee_addr[15:8] = cfg.wdata[15:8];
			if (cfg.be[3]) m_nxt.ee_rd = cfg.wdata[`MSL_EEI_KIND];
			if (cfg.be[2]) begin
				m_nxt.ee_data = cfg.wdata[`MSL_EEI_DATA +: 8];
				m_nxt.ee_busy = 1'b1;
				m_nxt.ee_done = 1'b0;
			end
		end
		if (m_r.ldw_v && ldw_unmapped) begin
			m_nxt.sts[`MSL_STS_UNMAP] = 1'b1;
		end

		case (m_r.st)
		M_BOOT: m_nxt.st = load_en ? M_LREQ : M_IDLE;
		M_LREQ: begin
			m_nxt.go = 1'b1;
			m_nxt.txn = '{dev: ee_dev, two_ptr: 1'b1, ptr: m_r.ptr, rd: 1'b1, wdata: 8'h00};
			m_nxt.st = M_LWAIT;
		end
		M_LWAIT: if (t_done) begin
			if (t_err != TE_NONE) begin
				m_nxt.sts = m_nxt.sts | err_bits(t_err);
				abort = 1'b1;
			end else begin
				m_nxt.sum = sm;
				m_nxt.ptr = m_r.ptr + 16'h0001;
				case (m_r.ph)
				P_B0: begin
					m_nxt.b0 = by;
					m_nxt.ph = P_B1;
				end
				P_B1: begin
					m_nxt.addr = {by[5:0], m_r.b0};
					m_nxt.cnt = 16'h0001;
					m_nxt.bi = 2'd0;
					m_nxt.ph = P_DATA;
					case (by[7:6])
					`MSL_TY_SEQ: m_nxt.ph = P_C0;
					`MSL_TY_BAD: begin
						m_nxt.sts[`MSL_STS_SUM] = 1'b1;
						abort = 1'b1;
					end
					`MSL_TY_DONE: begin
						if (sm != `MSL_SUM_OK && !m_r.skip) begin
							m_nxt.sts[`MSL_STS_SUM] = 1'b1;
							abort = 1'b1;
						end else begin
							fin = 1'b1;
						end
					end
					default: m_nxt.ph = P_DATA;
					endcase
				end
				P_C0: begin
					m_nxt.cnt[7:0] = by;
					m_nxt.ph = P_C1;
				end
				P_C1: begin
					m_nxt.cnt[15:8] = by;
					m_nxt.ph = ({by, m_r.cnt[7:0]} == 16'h0000) ? P_B0 : P_DATA;
				end
				default: begin
					// data arrives low byte first
					m_nxt.dw = {by, m_r.dw[31:8]};
					m_nxt.bi = m_r.bi + 2'd1;
					if (m_r.bi == 2'd3) begin
						m_nxt.ldw_v = 1'b1;
						m_nxt.ldw = '{addr: m_r.addr, data: {by, m_r.dw[31:8]}};
						m_nxt.addr = m_r.addr + 14'h0001;
						m_nxt.cnt = m_r.cnt - 16'h0001;
						if (m_r.cnt == 16'h0001) m_nxt.ph = P_B0;
					end
				end
				endcase
				if (!abort && !fin && m_r.ptr == `MSL_PTR_END) fin = 1'b1;
				if (!abort && !fin) m_nxt.st = M_LREQ;
			end
			if (abort) m_nxt.hold = 1'b1;
			if (abort || fin) begin
				m_nxt.sts[`MSL_STS_FIN] = 1'b1;
				m_nxt.st = M_IDLE;
			end
		end
		// reached once loading is over, or straight from boot when load_en is low
		M_IDLE: begin
			if (m_r.ee_busy) begin
				m_nxt.go = 1'b1;
				m_nxt.txn = '{dev: ee_dev, two_ptr: 1'b1, ptr: m_r.ee_addr, rd: m_r.ee_rd,
					wdata: m_r.ee_data};
				m_nxt.st = M_EWAIT;
			end else if (m_r.pend[m_r.scan] && (m_r.scan <= 4'h5 || m_r.scan >= `MSL_X_LINK)) begin
				m_nxt.xsel = m_r.scan;
				m_nxt.xstep = (m_r.scan == `MSL_X_PGOOD) ? 3'd2 : 3'd0;
				m_nxt.st = M_XREQ;
			end else begin
				// round robin keeps service latency equal
				m_nxt.pend[m_r.scan] = 1'b0;
				m_nxt.scan = (m_r.scan == `MSL_X_PGOOD) ? 4'h0 : m_r.scan + 4'h1;
			end
		end
		M_EWAIT: if (t_done) begin
			m_nxt.ee_busy = 1'b0;
			m_nxt.ee_done = 1'b1;
			if (m_r.ee_rd) m_nxt.ee_data = t_rdata;
			m_nxt.sts = m_nxt.sts | err_bits(t_err);
			m_nxt.st = M_IDLE;
		end
		M_XREQ: begin
			m_nxt.go = 1'b1;
			m_nxt.txn = '{dev: m_r.xaddr[m_r.xsel], two_ptr: 1'b0,
				ptr: {13'h0000, 3'(m_r.xstep + 3'd2)}, rd: m_r.xstep[2] & m_r.xstep[1],
				wdata: (m_r.xstep[2:1] == 2'd1) ? 8'h00 : wd};
			m_nxt.st = M_XWAIT;
		end
		M_XWAIT: if (t_done) begin
			if (t_err != TE_NONE) begin
				m_nxt.sts = m_nxt.sts | err_bits(t_err);
				xdone = 1'b1;
			end else begin
				if (m_r.xstep == 3'd6) m_nxt.xin[m_r.xsel][7:0] = t_rdata;
				if (m_r.xstep == 3'd7) m_nxt.xin[m_r.xsel][15:8] = t_rdata;
				if (m_r.xstep == ((m_r.xsel == `MSL_X_LINK || m_r.xsel == `MSL_X_ACT) ? 3'd5 : 3'd7)) begin
					xdone = 1'b1;
				end else begin
					m_nxt.xstep = m_r.xstep + 3'd1;
					m_nxt.st = M_XREQ;
				end
			end
			if (xdone) begin
				m_nxt.pend[m_r.xsel] = 1'b0;
				m_nxt.scan = (m_r.xsel == `MSL_X_PGOOD) ? 4'h0 : m_r.xsel + 4'h1;
				m_nxt.st = M_IDLE;
			end
		end
		default: m_nxt.st = M_IDLE;
		endcase

		// address field writes; a new write outranks a finishing service
		for (int e = 0; e <= 10; e++) begin
			if (cfg.wr && cfg.addr == `MSL_OFF_XA + 8'(4 * (e / 4)) && cfg.be[e % 4]) begin
				m_nxt.xaddr[e] = cfg.wdata[8 * (e % 4) +: 7];
				m_nxt.pend[e] = 1'b1;
			end
		end

		if (cfg.rd) begin
			case (cfg.addr)
			`MSL_OFF_CTL: m_nxt.rdata = {31'h00000000, m_r.skip};
			`MSL_OFF_STS: m_nxt.rdata = {26'h0000000, m_r.sts};
			`MSL_OFF_EEI: m_nxt.rdata = {5'h00, m_r.ee_busy, m_r.ee_done, m_r.ee_rd,
				m_r.ee_data, m_r.ee_addr};
			`MSL_OFF_XA: m_nxt.rdata = {1'b0, m_r.xaddr[3], 1'b0, m_r.xaddr[2],
				1'b0, m_r.xaddr[1], 1'b0, m_r.xaddr[0]};
			`MSL_OFF_XB: m_nxt.rdata = {1'b0, m_r.xaddr[7], 1'b0, m_r.xaddr[6],
				1'b0, m_r.xaddr[5], 1'b0, m_r.xaddr[4]};
			`MSL_OFF_XC: m_nxt.rdata = {9'h000, m_r.xaddr[10], 1'b0, m_r.xaddr[9],
				1'b0, m_r.xaddr[8]};
			default: m_nxt.rdata = 32'h00000000;
			endcase
		end
	end

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			m_r <= '0;
		end else begin
			m_r <= m_nxt;
		end
	end

	default clocking @(posedge clk_sys); endclocking
	default disable iff (sys_rst);

	sum_error_a: assert property (m_r.st == M_LWAIT && t_done && t_err == TE_NONE && m_r.ph == P_B1
		&& t_rdata[7:6] == `MSL_TY_DONE && !m_r.skip && 8'(m_r.sum + t_rdata) != `MSL_SUM_OK
		|=> m_r.sts[`MSL_STS_SUM] && m_r.hold && load_finished && m_r.st == M_IDLE)
		else $error("checksum mismatch not reported");
	sum_skip_a: assert property (m_r.st == M_LWAIT && t_done && t_err == TE_NONE && m_r.ph == P_B1
		&& t_rdata[7:6] == `MSL_TY_DONE && m_r.skip
		|=> load_finished && $stable(m_r.hold) && $stable(m_r.sts[`MSL_STS_SUM]))
		else $error("skipped checksum still acted on");
	bad_type_a: assert property (m_r.st == M_LWAIT && t_done && t_err == TE_NONE && m_r.ph == P_B1
		&& t_rdata[7:6] == `MSL_TY_BAD |=> m_r.sts[`MSL_STS_SUM] && m_r.hold && load_finished)
		else $error("undefined block type not reported");
	load_abort_a: assert property (m_r.st == M_LWAIT && t_done && t_err != TE_NONE
		|=> m_r.hold && load_finished && m_r.st == M_IDLE
		##1 !(m_r.st inside {M_LREQ, M_LWAIT}))
		else $error("bus error did not abort loading");
	no_early_x_a: assert property (m_r.st == M_XWAIT |-> load_finished || !load_en)
		else $error("expander access during loading");
	ee_complete_a: assert property (m_r.st == M_EWAIT && t_done
		|=> !m_r.ee_busy && m_r.ee_done && (!m_r.ee_rd || m_r.ee_data == $past(t_rdata)))
		else $error("eeprom access completion wrong");
	unmapped_a: assert property (m_r.ldw_v && ldw_unmapped |=> m_r.sts[`MSL_STS_UNMAP])
		else $error("unmapped write not flagged");
	x_cmd_a: assert property (m_r.st == M_XREQ |=> m_r.go && !m_r.txn.two_ptr
		&& 3'(m_r.txn.ptr[2:0] - 3'd2) == $past(m_r.xstep))
		else $error("expander command byte wrong");

	load_ok_c: cover property ($rose(load_finished) && !m_r.hold);
	ee_read_c: cover property (m_r.st == M_EWAIT && t_done && m_r.ee_rd);
	x_served_c: cover property (m_r.st == M_XWAIT && t_done && m_r.xstep == 3'd7);
endmodule

// ===== msl_bus_model.sv
`timescale 1ns/1ps
module msl_bus_model
	import msl_pkg::*;
(
	input  wire logic       clk_sys,
	input  wire logic       sys_rst,
	input  wire logic       be_go,
	input  wire msl_breq_t  be_req,
	input  wire logic [1:0] err_mode,
	input  wire logic       slow,
	output logic            be_done,
	output msl_brsp_t       be_rsp
);
	logic [7:0]  mem [256];
	logic [23:0] log_q [$];
	msl_breq_t   req;
	logic [6:0]  dev;
	logic [15:0] ptr;
	logic [7:0]  cmd;
	logic [2:0]  idx;
	logic [2:0]  wait_n;
	logic        busy;
	logic        hit;
	int          arb_n;
	// eeprom sits at 101xxxx, any other address is an expander
	assign hit = (req.op == BO_START ? req.data[7:5] : dev[6:4]) == 3'h5;
	always @(posedge clk_sys) begin
		be_done <= 1'b0;
		// idle data toggles each cycle between the last byte and its inverse
		be_rsp <= '{data: ~be_rsp.data, default: 1'b0};
		if (sys_rst) begin
			busy   <= 1'b0;
			arb_n  <= 0;
			be_rsp <= '0;
		end else if (be_go && !busy) begin
			busy   <= 1'b1;
			req    <= be_req;
			wait_n <= slow ? 3'h5 : 3'h0;
		end else if (busy && wait_n != 3'h0) begin
			wait_n <= wait_n - 3'h1;
		end else if (busy) begin
			busy            <= 1'b0;
			be_done         <= 1'b1;
			be_rsp.nack     <= hit && err_mode == 2'h1 && req.op == BO_START;
			be_rsp.arb_lost <= hit && err_mode == 2'h2;
			be_rsp.bad_cond <= hit && err_mode == 2'h3;
			arb_n           <= arb_n + int'(hit && err_mode == 2'h2);
			case (req.op)
				BO_START: begin
					dev <= req.data[7:1];
					idx <= 3'h0;
				end
				BO_WR: begin
					idx <= idx + 3'h1;
					if (hit && idx == 3'h0)
						ptr[15:8] <= req.data;
					else if (hit && idx == 3'h1)
						ptr[7:0] <= req.data;
					else if (hit) begin
						mem[ptr[7:0]] <= req.data;
						ptr           <= ptr + 16'h1;
					end else if (idx == 3'h0)
						cmd <= req.data;
					else
						log_q.push_back({dev, 1'b0, cmd, req.data});
				end
				BO_RD: begin
					if (hit) begin
						be_rsp.data <= mem[ptr[7:0]];
						ptr         <= ptr + 16'h1;
					end else begin
						be_rsp.data <= 8'h30 + cmd;
						log_q.push_back({dev, 1'b1, cmd, 8'h30 + cmd});
					end
				end
				default: ;
			endcase
		end
	end
endmodule

// ===== master_smbus_eeprom_loader_ioexp_bench.sv
`timescale 1ns/1ps
`include "msl_defines.svh"
module master_smbus_eeprom_loader_ioexp_bench
	import msl_pkg::*;
;
	logic              clk_sys = 1'b0;
	logic              sys_rst = 1'b1;
	logic              load_en = 1'b1;
	msl_cfg_t          cfg = '0;
	logic [11:0]       port_en = 12'hFFD;
	logic [11:0]       link_up = 12'h00F;
	logic [1:0]        err_mode = 2'h0;
	logic              slow = 1'b0;
	logic [31:0]       cfg_rdata;
	logic              ldw_valid;
	msl_ldw_t          ldw;
	logic              ldw_unmapped;
	logic              hold_after_reset;
	logic              load_finished;
	logic [10:0][15:0] exp_in;
	logic              be_go;
	msl_breq_t         be_req;
	logic              be_done;
	msl_brsp_t         be_rsp;
	msl_ldw_t          ldw_last;
	int                fails = 0;
	int                check_count = 0;
	int                ldw_cnt = 0;
	int                early_x = 0;

	msl_loader DUT (.clk_sys(clk_sys), .sys_rst(sys_rst), .load_en(load_en),
		.ee_addr_sel(4'h3), .cfg(cfg), .cfg_rdata(cfg_rdata), .ldw_valid(ldw_valid),
		.ldw(ldw), .ldw_unmapped(ldw_unmapped), .hold_after_reset(hold_after_reset),
		.load_finished(load_finished), .port_en(port_en), .link_up(link_up),
		.link_act(12'h000), .hp_ovr(12'h000), .hp_ctl('0), .exp_in(exp_in),
		.be_go(be_go), .be_req(be_req), .be_done(be_done), .be_rsp(be_rsp));
	msl_bus_model mdl (.clk_sys(clk_sys), .sys_rst(sys_rst), .be_go(be_go),
		.be_req(be_req), .err_mode(err_mode), .slow(slow), .be_done(be_done),
		.be_rsp(be_rsp));

	always #10 clk_sys = ~clk_sys;
	// second dword of the image targets an undefined register
	assign ldw_unmapped = ldw_valid && ldw.addr == 14'h0011;
	always @(posedge clk_sys) begin
		if (ldw_valid) begin
			ldw_cnt++;
			ldw_last = ldw;
		end
		if (be_go && be_req.op == BO_START && be_req.data[7:5] != 3'h5 && !load_finished)
			early_x++;
	end

	task automatic tick();
		@(posedge clk_sys);
		#1;
	endtask
	task automatic check(input string nm, input logic [31:0] e, input logic [31:0] g);
		check_count++;
		if (g !== e) begin
			fails++;
			$display("wrong value %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic reg_wr(input logic [7:0] a, input logic [3:0] b, input logic [31:0] w);
		cfg = '{wr: 1'b1, rd: 1'b0, addr: a, be: b, wdata: w};
		tick();
		cfg = '0;
		tick();
	endtask
	task automatic reg_rd(input logic [7:0] a, output logic [31:0] d);
		cfg = '{wr: 1'b0, rd: 1'b1, addr: a, be: 4'hF, wdata: 32'h0};
		tick();
		d = cfg_rdata;
		cfg = '0;
		tick();
	endtask
	task automatic mk_img(input int kind);
		logic [7:0] s;
		logic [7:0] img [14] = '{8'h10, 8'h40, 8'h02, 8'h00, 8'h55, 8'h66, 8'h77,
			8'h88, 8'h11, 8'h22, 8'h33, 8'h44, 8'h00, 8'hC0};
		s = 8'h00;
		for (int i = 0; i < 14; i++) begin
			mdl.mem[i] = img[i];
			s += img[i];
		end
		mdl.mem[12] = ~s + 8'(kind == 1);
		mdl.mem[1] = kind == 2 ? 8'h80 : 8'h40;
	endtask
	task automatic boot(input logic [1:0] em);
		err_mode = em;
		sys_rst = 1'b1;
		tick();
		tick();
		ldw_cnt = 0;
		sys_rst = 1'b0;
	endtask
	task automatic wait_fin();
		for (int i = 0; i < 9000 && load_finished !== 1'b1; i++)
			tick();
	endtask
	task automatic ee_wait(output logic [31:0] d);
		d = 32'h0400_0000;
		for (int i = 0; i < 300 && (d[`MSL_EEI_BUSY] !== 1'b0 || d[`MSL_EEI_DONE] !== 1'b1); i++)
			reg_rd(`MSL_OFF_EEI, d);
	endtask

	task automatic t_errs();
		logic [31:0] d;
		for (int k = 0; k < 5; k++) begin
			slow = k[0];
			mk_img(k == 0 ? 1 : k == 1 ? 2 : 0);
			boot(k < 2 ? 2'h0 : 2'(k - 1));
			wait_fin();
			reg_rd(`MSL_OFF_STS, d);
			// a full image with a bad sum still hands over the unmapped dword first
			check("err sts", 32'h1 | (32'h1 << (k < 2 ? 1 : k)) | (k == 0 ? 32'h20 : 32'h0),
				d & 32'h3F);
			check("halt", 32'h1, {31'h0, hold_after_reset});
			if (k == 1)
				check("ldw after bad type", 32'h0, ldw_cnt);
			if (k == 3)
				check("arb losses", 32'd16, mdl.arb_n);
		end
	endtask
	task automatic t_skip();
		logic [31:0] d;
		mk_img(1);
		boot(2'h0);
		reg_wr(`MSL_OFF_CTL, 4'h1, 32'h1);
		wait_fin();
		reg_rd(`MSL_OFF_STS, d);
		check("skip sts", 32'h21, d & 32'h3F);
		check("skip halt", 32'h0, {31'h0, hold_after_reset});
	endtask
	task automatic t_load_ok();
		logic [31:0] d;
		mk_img(0);
		boot(2'h0);
		reg_wr(`MSL_OFF_XC, 4'h1, 32'h28);
		wait_fin();
		reg_rd(`MSL_OFF_STS, d);
		check("ok sts", 32'h21, d & 32'h3F);
		check("ok halt", 32'h0, {31'h0, hold_after_reset});
		check("ldw count", 32'd2, ldw_cnt);
		check("ldw data", 32'h4433_2211, ldw_last.data);
		check("ldw addr", 32'h11, {18'h0, ldw_last.addr});
		for (int i = 0; i < 3000 && mdl.log_q.size() < 3; i++)
			tick();
		check("early expander", 32'h0, early_x);
		check("link lo", {8'h0, 7'h28, 1'b0, 8'h02, 8'hF2}, mdl.log_q[0]);
		check("link hi", {8'h0, 7'h28, 1'b0, 8'h03, 8'hFF}, mdl.log_q[1]);
		check("link pol", {8'h0, 7'h28, 1'b0, 8'h04, 8'h00}, mdl.log_q[2]);
	endtask
	task automatic t_eeprom();
		logic [31:0] d;
		reg_wr(`MSL_OFF_EEI, 4'hB, 32'h0000_0080);
		reg_wr(`MSL_OFF_EEI, 4'h4, 32'h0077_0000);
		ee_wait(d);
		check("ee write", 32'h77, {24'h0, mdl.mem[8'h80]});
		mdl.mem[8'h81] = 8'h5A;
		reg_wr(`MSL_OFF_EEI, 4'hB, 32'h0100_0081);
		reg_wr(`MSL_OFF_EEI, 4'h4, 32'h0);
		ee_wait(d);
		check("ee read", 32'h035A_0081, d & 32'h07FF_FFFF);
		err_mode = 2'h1;
		reg_wr(`MSL_OFF_EEI, 4'h4, 32'h0);
		ee_wait(d);
		reg_rd(`MSL_OFF_STS, d);
		check("ee nack", 32'h4, d & 32'h4);
		err_mode = 2'h0;
	endtask
	task automatic t_exp();
		logic [7:0] xd [8] = '{8'h3F, 8'h5F, 8'h00, 8'h00, 8'h0F, 8'h0F, 8'h30, 8'h31};
		slow = 1'b1;
		mdl.log_q.delete();
		reg_wr(`MSL_OFF_XA, 4'h1, 32'h20);
		for (int i = 0; i < 5000 && mdl.log_q.size() < 8; i++)
			tick();
		// last read is logged before its stop and the input capture, slow mode
		repeat (15) tick();
		for (int i = 0; i < 8; i++)
			check("hot-plug seq", {8'h0, 7'h20, i > 5, 8'(i < 6 ? i + 2 : i - 6), xd[i]},
				mdl.log_q[i]);
		check("exp input", 32'h3130, {16'h0, exp_in[0]});
	endtask

	task automatic final_report();
		$display("checks %0d mismatches %0d", check_count, fails);
		if (fails == 0 && check_count > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	initial begin
		#1_000_000;
		fails++;
		final_report();
	end
	initial begin
		t_errs();
		t_skip();
		t_load_ok();
		t_eeprom();
		t_exp();
		final_report();
	end
endmodule
